// ===== hw/chroma_mac_lane.sv
/*
 * one colour lane: two signed chroma products, then their sum with
 * the bias and the aligned luma. two register stages, held on stall.
 * assumes gains and bias are stable or change between pixels only.
 */
`timescale 1ns/1ps
module chroma_mac_lane
    import color_matrix_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            advance,
    input  wire logic signed [GAIN_WIDTH-1:0]    gain_a,
    input  wire logic        [DATA_WIDTH-1:0]    chroma_a,
    input  wire logic signed [GAIN_WIDTH-1:0]    gain_b,
    input  wire logic        [DATA_WIDTH-1:0]    chroma_b,
    input  wire logic signed [PRODUCT_WIDTH-1:0] bias,
    input  wire logic        [DATA_WIDTH-1:0]    luma,
    output logic signed      [SUM_WIDTH-1:0]     sum
);

    logic signed [PRODUCT_WIDTH-1:0] prod_a;
    logic signed [PRODUCT_WIDTH-1:0] prod_b;
    logic        [DATA_WIDTH-1:0]    luma_d;
    logic signed [SUM_WIDTH-1:0]     luma_aligned;

    // chroma is unsigned, so a zero sign bit goes in front
    wire logic signed [DATA_WIDTH:0] chroma_a_s = $signed({1'b0, chroma_a});
    wire logic signed [DATA_WIDTH:0] chroma_b_s = $signed({1'b0, chroma_b});

    assign luma_aligned = $signed({{(SUM_WIDTH-DATA_WIDTH-GAIN_FRAC){1'b0}},
                                   luma_d, {GAIN_FRAC{1'b0}}});

    always_ff @(posedge clk) begin
        if (rst) begin
            prod_a <= '0;
            prod_b <= '0;
            luma_d <= '0;
        end else if (advance) begin
            prod_a <= PRODUCT_WIDTH'(gain_a * chroma_a_s);
            prod_b <= PRODUCT_WIDTH'(gain_b * chroma_b_s);
            luma_d <= luma;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sum <= '0;
        end else if (advance) begin
            sum <= SUM_WIDTH'(prod_a) + SUM_WIDTH'(prod_b)
                 + SUM_WIDTH'(bias) + luma_aligned;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    lane_formula_a: assert property (
        $past(advance, 2) && $past(advance) && $past(!rst, 2) &&
        $past(!rst) |->
        sum == SUM_WIDTH'(PRODUCT_WIDTH'($past(gain_a, 2)
                                         * $past(chroma_a_s, 2)))
             + SUM_WIDTH'(PRODUCT_WIDTH'($past(gain_b, 2)
                                         * $past(chroma_b_s, 2)))
             + SUM_WIDTH'($past(bias)) + $past(luma_aligned)
    ) else $error("lane sum does not match its inputs");

    lane_hold_a: assert property (
        !advance |=> $stable(sum)
    ) else $error("lane sum moved during a stall");

endmodule

// ===== hw/color_matrix_pkg.sv
/*
 * constants shared by the luma/chroma to rgb matrix datapath:
 * widths, register offsets, reset values and field positions.
 * assumes a single 100 MHz clock and fixed 8-bit components.
 */
package color_matrix_pkg;

    // ==================================================================
    // widths
    localparam int DATA_WIDTH    = 8;
    localparam int GAIN_WIDTH    = 17;
    localparam int PRODUCT_WIDTH = (DATA_WIDTH + GAIN_WIDTH > 32) ?
                                   32 : DATA_WIDTH + GAIN_WIDTH;
    localparam int SUM_WIDTH     = PRODUCT_WIDTH + 2;
    localparam int GAIN_FRAC     = 14;
    localparam int INT_WIDTH     = SUM_WIDTH - GAIN_FRAC;
    localparam int PIXEL_WIDTH   = 3 * DATA_WIDTH;
    localparam int CHANNELS      = 3;
    localparam int ADDR_WIDTH    = 12;
    localparam int REG_WIDTH     = 32;
    localparam int OCC_WIDTH     = 4;

    // ==================================================================
    // component positions in the stream words
    localparam int LUMA_LSB  = 0;
    localparam int CB_LSB    = DATA_WIDTH;
    localparam int CR_LSB    = 2 * DATA_WIDTH;

    // ==================================================================
    // register offsets
    localparam logic [ADDR_WIDTH-1:0] CONTROL_ADDR     = 12'h000;
    localparam logic [ADDR_WIDTH-1:0] STATE_ADDR       = 12'h004;
    localparam logic [ADDR_WIDTH-1:0] PIXEL_COUNT_ADDR = 12'h008;
    localparam logic [ADDR_WIDTH-1:0] UPPER_ADDR       = 12'h100;
    localparam logic [ADDR_WIDTH-1:0] LOWER_ADDR       = 12'h104;
    localparam logic [ADDR_WIDTH-1:0] RED_BIAS_ADDR    = 12'h108;
    localparam logic [ADDR_WIDTH-1:0] GREEN_BIAS_ADDR  = 12'h10c;
    localparam logic [ADDR_WIDTH-1:0] BLUE_BIAS_ADDR   = 12'h110;
    localparam logic [ADDR_WIDTH-1:0] RED_GAIN_ADDR    = 12'h114;
    localparam logic [ADDR_WIDTH-1:0] GREEN_CR_ADDR    = 12'h118;
    localparam logic [ADDR_WIDTH-1:0] GREEN_CB_ADDR    = 12'h11c;
    localparam logic [ADDR_WIDTH-1:0] BLUE_GAIN_ADDR   = 12'h120;

    // ==================================================================
    // control and state fields
    localparam int CLIP_BIT  = 0;
    localparam int CLAMP_BIT = 1;
    localparam int BUSY_BIT  = 0;
    localparam int READY_BIT = 1;
    localparam int STALL_BIT = 2;

    // ==================================================================
    // reset values
    localparam logic [DATA_WIDTH-1:0]    UPPER_RESET = 8'hff;
    localparam logic [DATA_WIDTH-1:0]    LOWER_RESET = 8'h00;
    localparam logic [GAIN_WIDTH-1:0]    GAIN_RESET  = 17'h00000;
    localparam logic [PRODUCT_WIDTH-1:0] BIAS_RESET  = '0;
    localparam logic                     CLIP_RESET  = 1'b0;
    localparam logic                     CLAMP_RESET = 1'b0;

    // entries that can hold data at once: skid, input, two mac, output
    localparam logic [OCC_WIDTH-1:0] MAX_OCCUPANCY = 4'h5;

endpackage

// ===== hw/luma_chroma_to_rgb_matrix.sv
/*
 * luma/chroma 4:4:4 to red/green/blue stream converter, register port.
 * assumes one clock, sync active-high reset, one-cycle strobes.
 */
`timescale 1ns/1ps
// Contract
// - each pixel carries one luma and two chroma samples and yields one red, green and blue pixel.
// - samples enter on a stream slave port and leave on a stream master port, with a register port for control.
// - size, pixel rate and frame rate are kept, each input pixel giving exactly one output pixel in order.
// - red is gain times Cr plus bias plus luma, green two gains on Cr and Cb plus bias plus luma, blue gain times Cb plus bias plus luma.
// - only the restricted form is supported, red from luma and Cr, blue from luma and Cb, green from all, luma weight one.
// - scaling, biases and the optional upper and lower limits are settable so outputs stay in a chosen range.
// - the four gains are 17-bit two's complement and the samples unsigned at the component width.
// - the product width is the smaller of 32 and the component width plus 17.
// - with clipping on, any result above the upper limit is replaced by that limit.
module luma_chroma_to_rgb_matrix
    import color_matrix_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [ADDR_WIDTH-1:0]  reg_addr,
    input  wire logic [REG_WIDTH-1:0]   reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [REG_WIDTH-1:0]   reg_rdata,
    input  wire logic [PIXEL_WIDTH-1:0] s_axis_tdata,
    input  wire logic                   s_axis_tvalid,
    output logic                        s_axis_tready,
    input  wire logic                   s_axis_tuser,
    input  wire logic                   s_axis_tlast,
    output logic      [PIXEL_WIDTH-1:0] m_axis_tdata,
    output logic                        m_axis_tvalid,
    input  wire logic                   m_axis_tready,
    output logic                        m_axis_tuser,
    output logic                        m_axis_tlast
);
    // ==================================================================
    // configuration registers
    logic                            clip_en;
    logic                            clamp_en;
    logic        [DATA_WIDTH-1:0]    output_upper_limit;
    logic        [DATA_WIDTH-1:0]    output_lower_limit;
    logic signed [PRODUCT_WIDTH-1:0] red_bias;
    logic signed [PRODUCT_WIDTH-1:0] green_bias;
    logic signed [PRODUCT_WIDTH-1:0] blue_bias;
    logic signed [GAIN_WIDTH-1:0]    red_chroma_gain;
    logic signed [GAIN_WIDTH-1:0]    green_cr_gain;
    logic signed [GAIN_WIDTH-1:0]    green_cb_gain;
    logic signed [GAIN_WIDTH-1:0]    blue_chroma_gain;
    logic        [REG_WIDTH-1:0]     pixel_count;
    // ==================================================================
    // pipeline state
    logic                   skid_valid;
    logic [PIXEL_WIDTH-1:0] skid_data;
    logic                   skid_sof;
    logic                   skid_eol;
    logic                   st0_valid;
    logic [PIXEL_WIDTH-1:0] st0_data;
    logic                   st0_sof;
    logic                   st0_eol;
    logic [1:0]             lane_valid;
    logic [1:0]             lane_sof;
    logic [1:0]             lane_eol;
    // ==================================================================
    // register decode
    wire logic wr_control  = reg_write && (reg_addr == CONTROL_ADDR);
    wire logic wr_upper    = reg_write && (reg_addr == UPPER_ADDR);
    wire logic wr_lower    = reg_write && (reg_addr == LOWER_ADDR);
    wire logic wr_r_bias   = reg_write && (reg_addr == RED_BIAS_ADDR);
    wire logic wr_g_bias   = reg_write && (reg_addr == GREEN_BIAS_ADDR);
    wire logic wr_b_bias   = reg_write && (reg_addr == BLUE_BIAS_ADDR);
    wire logic wr_r_gain   = reg_write && (reg_addr == RED_GAIN_ADDR);
    wire logic wr_gcr_gain = reg_write && (reg_addr == GREEN_CR_ADDR);
    wire logic wr_gcb_gain = reg_write && (reg_addr == GREEN_CB_ADDR);
    wire logic wr_b_gain   = reg_write && (reg_addr == BLUE_GAIN_ADDR);
    wire logic [GAIN_WIDTH-1:0]    wr_gain = reg_wdata[GAIN_WIDTH-1:0];
    wire logic [PRODUCT_WIDTH-1:0] wr_bias = reg_wdata[PRODUCT_WIDTH-1:0];
    wire logic [DATA_WIDTH-1:0]    wr_lim  = reg_wdata[DATA_WIDTH-1:0];
    wire logic pipe_busy = skid_valid || st0_valid || (|lane_valid)
                           || m_axis_tvalid;
    logic [REG_WIDTH-1:0] read_value;
    always_comb begin
        read_value = '0;
        case (reg_addr)
            CONTROL_ADDR: begin
                read_value[CLIP_BIT]  = clip_en;
                read_value[CLAMP_BIT] = clamp_en;
            end
            STATE_ADDR: begin
                read_value[BUSY_BIT]  = pipe_busy;
                read_value[READY_BIT] = s_axis_tready;
                read_value[STALL_BIT] = m_axis_tvalid && !m_axis_tready;
            end
            PIXEL_COUNT_ADDR: read_value = pixel_count;
            UPPER_ADDR: read_value = REG_WIDTH'(output_upper_limit);
            LOWER_ADDR: read_value = REG_WIDTH'(output_lower_limit);
            RED_BIAS_ADDR: read_value = REG_WIDTH'($unsigned(red_bias));
            GREEN_BIAS_ADDR: read_value = REG_WIDTH'($unsigned(green_bias));
            BLUE_BIAS_ADDR: read_value = REG_WIDTH'($unsigned(blue_bias));
            RED_GAIN_ADDR: read_value = REG_WIDTH'($unsigned(red_chroma_gain));
            GREEN_CR_ADDR: read_value = REG_WIDTH'($unsigned(green_cr_gain));
            GREEN_CB_ADDR: read_value = REG_WIDTH'($unsigned(green_cb_gain));
            BLUE_GAIN_ADDR: read_value = REG_WIDTH'($unsigned(blue_chroma_gain));
            default: read_value = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_read ? read_value : '0;
        end
    end

    // biases arrive already scaled and rounded by software
    always_ff @(posedge clk) begin
        if (rst) begin
            clip_en            <= CLIP_RESET;
            clamp_en           <= CLAMP_RESET;
            output_upper_limit <= UPPER_RESET;
            output_lower_limit <= LOWER_RESET;
            red_bias           <= BIAS_RESET;
            green_bias         <= BIAS_RESET;
            blue_bias          <= BIAS_RESET;
        end else begin
            if (wr_control) begin
                clip_en  <= reg_wdata[CLIP_BIT];
                clamp_en <= reg_wdata[CLAMP_BIT];
            end
            if (wr_upper)  output_upper_limit <= wr_lim;
            if (wr_lower)  output_lower_limit <= wr_lim;
            if (wr_r_bias) red_bias   <= $signed(wr_bias);
            if (wr_g_bias) green_bias <= $signed(wr_bias);
            if (wr_b_bias) blue_bias  <= $signed(wr_bias);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            red_chroma_gain  <= GAIN_RESET;
            green_cr_gain    <= GAIN_RESET;
            green_cb_gain    <= GAIN_RESET;
            blue_chroma_gain <= GAIN_RESET;
        end else begin
            if (wr_r_gain)   red_chroma_gain  <= $signed(wr_gain);
            if (wr_gcr_gain) green_cr_gain    <= $signed(wr_gain);
            if (wr_gcb_gain) green_cb_gain    <= $signed(wr_gain);
            if (wr_b_gain)   blue_chroma_gain <= $signed(wr_gain);
        end
    end
    // ==================================================================
    // stream input with a one-entry skid so ready comes from a flop
    wire logic advance  = !m_axis_tvalid || m_axis_tready;
    wire logic s_fire   = s_axis_tvalid && s_axis_tready;
    wire logic out_fire = m_axis_tvalid && m_axis_tready;

    wire logic next_skid_valid = advance ? 1'b0 : (skid_valid || s_fire);

    always_ff @(posedge clk) begin
        if (rst) begin
            skid_valid    <= 1'b0;
            s_axis_tready <= 1'b0;
        end else begin
            skid_valid    <= next_skid_valid;
            s_axis_tready <= !next_skid_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            skid_data <= '0;
            skid_sof  <= 1'b0;
            skid_eol  <= 1'b0;
        end else if (!advance && s_fire) begin
            skid_data <= s_axis_tdata;
            skid_sof  <= s_axis_tuser;
            skid_eol  <= s_axis_tlast;
        end
    end

    // first stage takes the parked pixel before any new one
    always_ff @(posedge clk) begin
        if (rst) begin
            st0_valid <= 1'b0;
            st0_data  <= '0;
            st0_sof   <= 1'b0;
            st0_eol   <= 1'b0;
        end else if (advance) begin
            st0_valid <= skid_valid || s_fire;
            st0_data  <= skid_valid ? skid_data : s_axis_tdata;
            st0_sof   <= skid_valid ? skid_sof : s_axis_tuser;
            st0_eol   <= skid_valid ? skid_eol : s_axis_tlast;
        end
    end

    // markers follow the two lane stages
    always_ff @(posedge clk) begin
        if (rst) begin
            lane_valid <= '0;
            lane_sof   <= '0;
            lane_eol   <= '0;
        end else if (advance) begin
            lane_valid <= {lane_valid[0], st0_valid};
            lane_sof   <= {lane_sof[0], st0_sof};
            lane_eol   <= {lane_eol[0], st0_eol};
        end
    end
    // ==================================================================
    // colour lanes: red, green, blue
    wire logic [DATA_WIDTH-1:0] luma = st0_data[LUMA_LSB +: DATA_WIDTH];
    wire logic [DATA_WIDTH-1:0] cb   = st0_data[CB_LSB +: DATA_WIDTH];
    wire logic [DATA_WIDTH-1:0] cr   = st0_data[CR_LSB +: DATA_WIDTH];

    logic signed [GAIN_WIDTH-1:0]    gain_a [CHANNELS];
    logic signed [GAIN_WIDTH-1:0]    gain_b [CHANNELS];
    logic signed [PRODUCT_WIDTH-1:0] bias   [CHANNELS];
    logic signed [SUM_WIDTH-1:0]     sum    [CHANNELS];
    logic        [DATA_WIDTH-1:0]    limited[CHANNELS];

    // a-term multiplies Cr, b-term Cb; unused terms are zero gain
    assign gain_a[0] = red_chroma_gain;
    assign gain_b[0] = '0;
    assign gain_a[1] = green_cr_gain;
    assign gain_b[1] = green_cb_gain;
    assign gain_a[2] = '0;
    assign gain_b[2] = blue_chroma_gain;
    assign bias[0]   = red_bias;
    assign bias[1]   = green_bias;
    assign bias[2]   = blue_bias;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_lane
            chroma_mac_lane u_lane (
                .clk     (clk),
                .rst     (rst),
                .advance (advance),
                .gain_a  (gain_a[ch]),
                .chroma_a(cr),
                .gain_b  (gain_b[ch]),
                .chroma_b(cb),
                .bias    (bias[ch]),
                .luma    (luma),
                .sum     (sum[ch])
            );
            output_range_limiter u_limit (
                .sum     (sum[ch]),
                .clip_en (clip_en),
                .clamp_en(clamp_en),
                .upper   (output_upper_limit),
                .lower   (output_lower_limit),
                .result  (limited[ch])
            );
        end
    endgenerate
    // ==================================================================
    // stream output
    always_ff @(posedge clk) begin
        if (rst) begin
            m_axis_tvalid <= 1'b0;
            m_axis_tdata  <= '0;
            m_axis_tuser  <= 1'b0;
            m_axis_tlast  <= 1'b0;
        end else if (advance) begin
            m_axis_tvalid <= lane_valid[1];
            m_axis_tdata  <= {limited[2], limited[1], limited[0]};
            m_axis_tuser  <= lane_sof[1];
            m_axis_tlast  <= lane_eol[1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pixel_count <= '0;
        end else if (out_fire) begin
            pixel_count <= pixel_count + 1'b1;
        end
    end
    // ==================================================================
    // checks
    logic [REG_WIDTH-1:0] in_count;
    logic [REG_WIDTH-1:0] sof_in;
    logic [REG_WIDTH-1:0] sof_out;
    wire logic [REG_WIDTH-1:0] occ_full = in_count - pixel_count;

    always_ff @(posedge clk) begin
        if (rst) begin
            in_count <= '0;
            sof_in   <= '0;
            sof_out  <= '0;
        end else begin
            if (s_fire) in_count <= in_count + 1'b1;
            if (s_fire && s_axis_tuser) sof_in <= sof_in + 1'b1;
            if (out_fire && m_axis_tuser) sof_out <= sof_out + 1'b1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    pixel_balance_a: assert property (
        occ_full <= REG_WIDTH'(MAX_OCCUPANCY)
    ) else $error("more pixels in flight than the pipeline holds");
    frame_marker_a: assert property (
        !pipe_busy |-> sof_in == sof_out
    ) else $error("start-of-frame markers lost or duplicated");
    flow_latency_a: assert property (
        (s_fire && m_axis_tready) ##1 m_axis_tready [*3] |=> m_axis_tvalid
    ) else $error("pixel not out four cycles after acceptance");
    stall_hold_a: assert property (
        m_axis_tvalid && !m_axis_tready |=>
        m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tuser)
    ) else $error("output changed while stalled");
    skid_ready_a: assert property (
        skid_valid |-> !s_axis_tready
    ) else $error("ready high while a pixel is parked");
    for (genvar k = 0; k < CHANNELS; k++) begin : g_chk
        upper_clip_a: assert property (
            advance && lane_valid[1] && clip_en &&
            (sum[k] >>> GAIN_FRAC) > $signed({1'b0, output_upper_limit}) |=>
            m_axis_tdata[k*DATA_WIDTH +: DATA_WIDTH]
                == $past(output_upper_limit)
        ) else $error("clipped output not at the upper limit");
        lower_clamp_a: assert property (
            advance && lane_valid[1] && clamp_en && !clip_en &&
            (sum[k] >>> GAIN_FRAC) < $signed({1'b0, output_lower_limit}) |=>
            m_axis_tdata[k*DATA_WIDTH +: DATA_WIDTH]
                == $past(output_lower_limit)
        ) else $error("clamped output not at the lower limit");
    end
    read_timing_a: assert property (
        !reg_read |=> reg_rdata == '0
    ) else $error("read data present without a read");

endmodule

// ===== hw/output_range_limiter.sv
/*
 * drops the fraction of a lane sum and limits it to the programmed
 * window. combinational; the caller registers the result.
 * assumes lower limit is not above upper limit when both are on.
 */
`timescale 1ns/1ps
module output_range_limiter
    import color_matrix_pkg::*;
(
    input  wire logic signed [SUM_WIDTH-1:0]  sum,
    input  wire logic                         clip_en,
    input  wire logic                         clamp_en,
    input  wire logic        [DATA_WIDTH-1:0] upper,
    input  wire logic        [DATA_WIDTH-1:0] lower,
    output logic             [DATA_WIDTH-1:0] result
);

    wire logic signed [INT_WIDTH-1:0] whole = sum[SUM_WIDTH-1:GAIN_FRAC];
    wire logic signed [INT_WIDTH-1:0] upper_s =
        $signed({{(INT_WIDTH-DATA_WIDTH){1'b0}}, upper});
    wire logic signed [INT_WIDTH-1:0] lower_s =
        $signed({{(INT_WIDTH-DATA_WIDTH){1'b0}}, lower});
    wire logic over  = clip_en && (whole > upper_s);
    wire logic under = clamp_en && (whole < lower_s);

    // without limits the value wraps to the component width
    assign result = over  ? upper :
                    under ? lower :
                            whole[DATA_WIDTH-1:0];

endmodule

// ===== tb/luma_chroma_to_rgb_matrix_tb.sv
/* bench: random gains, biases, limits and pixels, four configurations.
   assumes the sink model beside it drives output back-pressure. */
`timescale 1ns/1ps
module luma_chroma_to_rgb_matrix_tb
    import color_matrix_pkg::*;
;
    logic                   clk = 0, rst = 1, reg_write = 0, reg_read = 0;
    logic [ADDR_WIDTH-1:0]  reg_addr = '0;
    logic [REG_WIDTH-1:0]   reg_wdata = '0, reg_rdata;
    logic [PIXEL_WIDTH-1:0] s_axis_tdata = '0, m_axis_tdata;
    logic                   s_axis_tvalid = 0, s_axis_tuser = 0;
    logic                   s_axis_tlast = 0, s_axis_tready, m_axis_tvalid;
    logic                   m_axis_tready, m_axis_tuser, m_axis_tlast;
    logic                   stall_en = 0;
    int                     n_mismatch = 0, samples_checked = 0;
    int                     g[4], b[3], ctl, up, lo;
    logic [25:0]            exp_q[$];
    luma_chroma_to_rgb_matrix dut_u (.clk, .rst, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .s_axis_tdata, .s_axis_tvalid,
        .s_axis_tready, .s_axis_tuser, .s_axis_tlast, .m_axis_tdata,
        .m_axis_tvalid, .m_axis_tready, .m_axis_tuser, .m_axis_tlast);
    stream_sink_model sink_u (.clk, .rst, .stall_en, .tready(m_axis_tready));
    initial forever #5 clk = ~clk;
    task automatic fail(string m);
        n_mismatch++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [7:0] px(int ga, ca, gb, cb, bias, y);
        int v;
        v = (ga * ca + gb * cb + bias + (y <<< 14)) >>> 14;
        if (ctl[0] && v > up)
            v = up;
        else if (ctl[1] && v < lo)
            v = lo;
        return v[7:0];
    endfunction
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1;
        @(posedge clk);
        reg_write <= 0;
        @(posedge clk);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge clk);
        reg_read <= 0;
        @(posedge clk);
        samples_checked++;
        if (reg_rdata !== e)
            fail("register read");
    endtask
    // ==================================================================
    // scoreboard: note at input handshake, compare at output handshake
    always @(posedge clk) begin
        if (s_axis_tvalid && s_axis_tready)
            exp_q.push_back({s_axis_tuser, s_axis_tlast,
                px(g[3], s_axis_tdata[15:8], 0, 0, b[2], s_axis_tdata[7:0]),
                px(g[1], s_axis_tdata[23:16], g[2], s_axis_tdata[15:8],
                   b[1], s_axis_tdata[7:0]),
                px(g[0], s_axis_tdata[23:16], 0, 0, b[0], s_axis_tdata[7:0])});
        if (m_axis_tvalid && m_axis_tready) begin
            samples_checked++;
            if (exp_q.size() == 0 || {m_axis_tuser, m_axis_tlast,
                m_axis_tdata} !== exp_q.pop_front())
                fail("pixel mismatch");
        end
    end
    // ==================================================================
    // main sequence
    initial begin
        void'($urandom(92));
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(UPPER_ADDR, 32'h0000_00ff);
        rd(12'h200, 32'h0);
        for (int p = 0; p < 4; p++) begin
            ctl = p;
            up = $urandom_range(255, 128);
            lo = $urandom_range(64, 0);
            for (int i = 0; i < 4; i++) begin
                g[i] = $urandom_range(65535) - 32768;
                wr(RED_GAIN_ADDR + 12'(4 * i), 32'(g[i]) & 32'h1ffff);
            end
            rd(GREEN_CB_ADDR, 32'(g[2]) & 32'h1ffff);
            for (int i = 0; i < 3; i++) begin
                b[i] = $urandom_range(4194304) - 2097152;
                wr(RED_BIAS_ADDR + 12'(4 * i), 32'(b[i]) & 32'h1ffffff);
            end
            wr(UPPER_ADDR, 32'(up));
            wr(LOWER_ADDR, 32'(lo));
            wr(CONTROL_ADDR, 32'(ctl));
            rd(CONTROL_ADDR, 32'(ctl));
            stall_en <= p[0];
            for (int k = 0; k < 200; k++) begin
                if ($urandom_range(3) == 0) begin
                    s_axis_tvalid <= 0;
                    @(posedge clk);
                end
                s_axis_tvalid <= 1;
                s_axis_tdata <= PIXEL_WIDTH'($urandom);
                s_axis_tuser <= (k == 0);
                s_axis_tlast <= (k % 8 == 7);
                do @(posedge clk); while (!s_axis_tready);
            end
            s_axis_tvalid <= 0;
            for (int w = 0; w < 200 && exp_q.size() != 0; w++)
                @(posedge clk);
            if (exp_q.size() != 0)
                fail("pixels not drained");
        end
        rd(STATE_ADDR, 32'h0000_0002);
        rd(PIXEL_COUNT_ADDR, 32'd800);
        give_verdict;
    end
    initial begin
        #200000;
        fail("timeout");
        give_verdict;
    end
endmodule

// ===== tb/stream_sink_model.sv
/* downstream pixel sink: takes pixels, stalls at random when asked.
   assumes the bench seeds the random generator once. */
`timescale 1ns/1ps
module stream_sink_model
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic stall_en,
    output logic      tready
);
    initial tready = 1'b1;
    always @(posedge clk) begin
        tready <= rst || !stall_en || ($urandom_range(2) != 0);
    end
endmodule
